// ### host_model.sv
/* host-side model driving the control pins of the power sequencer.
   assumes the bench calls its tasks; released pins are driven high by the model itself, in place of pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // clock
   input  wire logic clk_i,
   // pins to the device
   output var  logic supply_valid_o,
   output var  logic switch_request_n_o,
   output var  logic emergency_reset_n_o,
   output var  logic wake_pin_a_o,
   output var  logic wake_pin_b_o,
   output var  logic usb_resume_o
);
   initial begin
      supply_valid_o      = 1'b1;
      switch_request_n_o  = 1'b1;
      emergency_reset_n_o = 1'b1;
      {wake_pin_a_o, wake_pin_b_o, usb_resume_o} = 3'h0;
   end
   // ------------------------------------------
   // pin actions, each launched after an edge
   // ------------------------------------------
   task automatic press(input int n);
      @(posedge clk_i) switch_request_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      switch_request_n_o <= 1'b1;
   endtask : press
   task automatic rise(input logic b);
      @(posedge clk_i) {wake_pin_b_o, wake_pin_a_o} <= b ? 2'h2 : 2'h1;
      repeat (3) @(posedge clk_i);
      {wake_pin_b_o, wake_pin_a_o} <= 2'h0;
   endtask : rise
   task automatic resume;
      @(posedge clk_i) usb_resume_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      usb_resume_o <= 1'b0;
   endtask : resume
   task automatic erst(input logic lvl);
      @(posedge clk_i) emergency_reset_n_o <= lvl;
   endtask : erst
   task automatic supply(input logic lvl);
      @(posedge clk_i) supply_valid_o <= lvl;
   endtask : supply
endmodule : host_model
`default_nettype wire

// ### module_power_state_control.sv
/*
 * power-state sequencer: switch-on, deep sleep and wake, graceful,
 * fast and memory-safe switch-off, graceful and abrupt reset.
 * assumes synchronous pins, one 250 MHz clock, a classic wishbone master
 * and board pull-ups modelled by the pull-up enable outputs.
 */
// The implementer's own choices: the register offsets and register access over Wishbone.
// Behaviour
// - power-on needs valid supply then long press
// - off with supply: long press starts switch-on
// - deep sleep: long press starts wake-up
// - low power mode 5: wake pin rise wakes
// - usb sleep 0 with usb host: resume wakes
// - switch request pin pulled up internally
// - pins tri-stated until io rail is on
// - reset held low, then pins released in sequence
// - ready only after all interfaces configured
// - off command or valid pulse: graceful off
// - function 10 or fast pin: store, no detach
// - function 11 or safe pin: inhibit flash, off
// - accepted off command answers ok
// - end of off: tri-state pins, rail off
// - stay off until switch request low
// - function 16: store, detach, then reboot
// - emergency reset held low: abrupt reset
// - emergency reset pulled up, cuts all regulators
// - io rail on only when on, awake
// - deep sleep: interfaces dead, only wake events
`timescale 1ns/10ps
`default_nettype none

module module_power_state_control #(
   parameter int N_PINS        = 8,
   parameter int ON_CYCLES     = power_seq_pkg::ON_CYC,
   parameter int WAKE_CYCLES   = power_seq_pkg::WAKE_CYC,
   parameter int OFF_CYCLES    = power_seq_pkg::OFF_CYC,
   parameter int ERST_CYCLES   = power_seq_pkg::ERST_CYC,
   parameter int RST_CYCLES    = power_seq_pkg::RST_CYC,
   parameter int STEP_CYCLES   = power_seq_pkg::STEP_CYC,
   parameter int RAIL_CYCLES   = power_seq_pkg::RAIL_CYC,
   parameter int STORE_CYCLES  = power_seq_pkg::STORE_CYC,
   parameter int DETACH_CYCLES = power_seq_pkg::DETACH_CYC,
   parameter int SHUT_CYCLES   = power_seq_pkg::SHUT_CYC
) (
   // clock and reset
   input  wire  logic                      clk_i,
   input  wire  logic                      rst_i,
   // register bus
   input  wire  power_seq_pkg::wb_req_type wb_req_i,
   output var   power_seq_pkg::wb_rsp_type wb_rsp_o,
   // control pins from the host
   input  wire  logic                      supply_valid_i,
   input  wire  logic                      switch_request_n_i,
   input  wire  logic                      emergency_reset_n_i,
   input  wire  logic                      wake_pin_a_i,
   input  wire  logic                      wake_pin_b_i,
   input  wire  logic                      usb_resume_i,
   // pull-up enables
   output logic                            switch_request_pullup_o,
   output logic                            emergency_reset_pullup_o,
   // power, reset and pin control
   output logic                            io_rail_out_o,
   output logic                            internal_reset_n_o,
   output logic                            pin_tristate_o,
   output logic [N_PINS-1:0]               pin_enable_o,
   output logic                            nvm_store_o,
   output logic                            net_detach_o,
   output logic                            flash_inhibit_o,
   output logic                            ready_o,
   output logic                            greeting_o
);
   import power_seq_pkg::*;

   localparam int CW = 16;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      pwr_st_type        st;
      logic [CW-1:0]     cnt;
      logic [CW-1:0]     press;
      logic [CW-1:0]     ehold;
      logic              armed;
      logic              prev_a;
      logic              prev_b;
      cfg_type           cfg;
      logic              off_ok;
      logic              reboot;
      logic              no_detach;
      logic              safe;
      logic [N_PINS-1:0] pins;
      logic              rail;
      logic              rst_n;
      logic              tri_st;
      logic              ready;
      logic              greet;
      logic              ack;
      logic [31:0]       dat;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   function automatic state_type enter(input state_type x, input pwr_st_type t);
      state_type y;
      y       = x;
      y.st    = t;
      y.cnt   = '0;
      y.armed = 1'b0;
      return y;
   endfunction : enter

   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
      return (v == '1) ? v : v + 1'b1;
   endfunction : sat_inc

   logic          req;
   logic          wr;
   logic          bus_live;
   logic          rise_a;
   logic          rise_b;
   logic          wake_trig;
   logic          safe_trig;
   logic          fast_trig;
   logic          off_trig;
   logic          erst_trig;
   logic [7:0]    wr_func;

   // ------------------------------------------------------------
   // trigger decode
   // ------------------------------------------------------------
   assign req       = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
   // writes land on the edge at which the master samples ack high
   assign wr        = wb_req_i.cyc & wb_req_i.stb & s_r.ack & wb_req_i.we & wb_req_i.sel[0];
   assign bus_live  = (s_r.st == ST_ACTIVE);
   assign wr_func   = (wr && bus_live && wb_req_i.adr[7:2] == FUNC_OFS[7:2]) ? wb_req_i.dat[7:0] : 8'h00;
   assign rise_a    = wake_pin_a_i & ~s_r.prev_a;
   assign rise_b    = wake_pin_b_i & ~s_r.prev_b;
   assign wake_trig = (s_r.cfg.low_power == LPC_WAKE_PINS)
                      && ((rise_a && s_r.cfg.func_a == PF_WAKE)
                      || (rise_b && s_r.cfg.func_b == PF_WAKE));
   assign safe_trig = (wr_func == FUNC_SAFE_OFF)
                      || (rise_a && s_r.cfg.func_a == PF_SAFE_OFF)
                      || (rise_b && s_r.cfg.func_b == PF_SAFE_OFF);
   assign fast_trig = (wr_func == FUNC_FAST_OFF)
                      || (rise_a && s_r.cfg.func_a == PF_FAST_OFF)
                      || (rise_b && s_r.cfg.func_b == PF_FAST_OFF);
   assign off_trig  = switch_request_n_i && s_r.armed
                      && s_r.press >= CW'(OFF_CYCLES);
   assign erst_trig = !emergency_reset_n_i && s_r.ehold >= CW'(ERST_CYCLES - 1)
                      && s_r.st != ST_OFF && s_r.st != ST_ABRUPT;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt        = s_r;
      s_nxt.ack    = 1'b0;
      s_nxt.greet  = 1'b0;
      s_nxt.prev_a = wake_pin_a_i;
      s_nxt.prev_b = wake_pin_b_i;
      s_nxt.cnt    = sat_inc(s_r.cnt);
      s_nxt.press  = switch_request_n_i ? '0 : sat_inc(s_r.press);
      s_nxt.ehold  = emergency_reset_n_i ? '0 : sat_inc(s_r.ehold);
      s_nxt.armed  = s_r.armed | switch_request_n_i;

      // bus slave: one wait state, unmapped reads as zero
      if (req) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = 32'h0000_0000;
         unique case (wb_req_i.adr[7:2])
            CFG_OFS[7:2]:  s_nxt.dat = {19'h0, s_r.cfg};
            STAT_OFS[7:2]: s_nxt.dat = {24'h0, s_r.safe, s_r.off_ok, s_r.rail, s_r.ready, s_r.st};
            default:       s_nxt.dat = 32'h0000_0000;
         endcase
      end
      // cfg bytes, only while active, on the acknowledged edge
      if (wb_req_i.cyc && wb_req_i.stb && s_r.ack && wb_req_i.we && bus_live
          && wb_req_i.adr[7:2] == CFG_OFS[7:2]) begin
         if (wb_req_i.sel[0]) begin
            s_nxt.cfg[7:0] = wb_req_i.dat[7:0];
         end
         if (wb_req_i.sel[1]) begin
            s_nxt.cfg[12:8] = wb_req_i.dat[12:8];
         end
      end

      unique case (s_r.st)
         ST_OFF: begin
            if (supply_valid_i && !switch_request_n_i && s_r.press >= CW'(ON_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, ST_RAIL_UP);
            end
         end
         ST_RAIL_UP: begin
            s_nxt.off_ok = 1'b0;
            s_nxt.safe   = 1'b0;
            s_nxt.reboot = 1'b0;
            if (s_r.cnt >= CW'(RST_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, ST_PIN_SEQ);
            end
         end
         ST_PIN_SEQ: begin
            if (s_r.cnt >= CW'(STEP_CYCLES - 1)) begin
               s_nxt.cnt = '0;
               if (&s_r.pins) begin
                  s_nxt       = enter(s_nxt, ST_ACTIVE);
                  s_nxt.greet = s_r.cfg.greet;
               end else begin
                  s_nxt.pins = {s_r.pins[N_PINS-2:0], 1'b1};
               end
            end
         end
         ST_ACTIVE: begin
            if (safe_trig) begin
               s_nxt.safe = 1'b1;
               s_nxt      = enter(s_nxt, ST_SHUTDOWN);
            end else if (fast_trig) begin
               s_nxt.no_detach = 1'b1;
               s_nxt           = enter(s_nxt, ST_STORE);
            end else if (off_trig || (wr && wb_req_i.adr[7:2] == CTRL_OFS[7:2]
                                      && wb_req_i.dat[CTRL_OFF_BIT])) begin
               s_nxt.off_ok    = wr;
               s_nxt.no_detach = 1'b0;
               s_nxt           = enter(s_nxt, ST_STORE);
            end else if (wr_func == FUNC_REBOOT) begin
               s_nxt.reboot    = 1'b1;
               s_nxt.no_detach = 1'b0;
               s_nxt           = enter(s_nxt, ST_STORE);
            end else if (wr && wb_req_i.adr[7:2] == CTRL_OFS[7:2] && wb_req_i.dat[CTRL_SLEEP_BIT]) begin
               s_nxt = enter(s_nxt, ST_SLEEP);
            end
         end
         // pins keep their enables, rail is off
         ST_SLEEP: begin
            if ((!switch_request_n_i && s_r.press >= CW'(WAKE_CYCLES - 1))
                || wake_trig
                || (s_r.cfg.usb_sleep == USB_SLP_RESUME && s_r.cfg.usb_host
                    && usb_resume_i)) begin
               s_nxt = enter(s_nxt, ST_WAKE);
            end
         end
         ST_WAKE: begin
            if (s_r.cnt >= CW'(RAIL_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, ST_ACTIVE);
            end
         end
         // switch-off routine runs to its end unless supply loss or emergency reset overrides, other triggers ignored
         ST_STORE: begin
            if (s_r.cnt >= CW'(STORE_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, s_r.no_detach ? ST_SHUTDOWN : ST_DETACH);
            end
         end
         ST_DETACH: begin
            if (s_r.cnt >= CW'(DETACH_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, ST_SHUTDOWN);
            end
         end
         ST_SHUTDOWN: begin
            s_nxt.pins = '0;
            if (s_r.cnt >= CW'(SHUT_CYCLES - 1)) begin
               s_nxt = enter(s_nxt, s_r.reboot ? ST_RAIL_UP : ST_OFF);
            end
         end
         ST_ABRUPT: begin
            if (emergency_reset_n_i) begin
               s_nxt = enter(s_nxt, ST_RAIL_UP);
            end
         end
      endcase

      // overrides: supply loss first, then abrupt reset
      if (!supply_valid_i) begin
         s_nxt      = enter(s_nxt, ST_OFF);
         s_nxt.pins = '0;
      end else if (erst_trig) begin
         s_nxt      = enter(s_nxt, ST_ABRUPT);
         s_nxt.pins = '0;
      end

      // registered outputs follow the next state
      s_nxt.rail   = s_nxt.st inside {ST_RAIL_UP, ST_PIN_SEQ, ST_ACTIVE, ST_WAKE,
                                      ST_STORE, ST_DETACH, ST_SHUTDOWN};
      s_nxt.rst_n  = s_nxt.st inside {ST_PIN_SEQ, ST_ACTIVE, ST_SLEEP, ST_WAKE,
                                      ST_STORE, ST_DETACH};
      s_nxt.tri_st = !(s_nxt.st inside {ST_PIN_SEQ, ST_ACTIVE, ST_STORE, ST_DETACH});
      s_nxt.ready  = (s_nxt.st == ST_ACTIVE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r        <= '0;
         s_r.st     <= ST_OFF;
         s_r.cfg    <= CFG_RESET;
         s_r.tri_st <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign switch_request_pullup_o  = 1'b1;
   assign emergency_reset_pullup_o = 1'b1;
   assign wb_rsp_o.ack             = s_r.ack;
   assign wb_rsp_o.dat             = s_r.dat;
   assign io_rail_out_o            = s_r.rail;
   assign internal_reset_n_o       = s_r.rst_n;
   assign pin_tristate_o           = s_r.tri_st;
   assign pin_enable_o             = s_r.pins;
   assign nvm_store_o              = (s_r.st == ST_STORE);
   assign net_detach_o             = (s_r.st == ST_DETACH);
   assign flash_inhibit_o          = s_r.safe;
   assign ready_o                  = s_r.ready;
   assign greeting_o               = s_r.greet;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic quiet;
   assign quiet = supply_valid_i & emergency_reset_n_i;

   a_supply_gate: assert property (s_r.st == ST_OFF && !supply_valid_i |=> s_r.st == ST_OFF)
      else $error("switch-on without valid supply");
   a_switch_on: assert property (s_r.st == ST_OFF && quiet && !switch_request_n_i
                                 && s_r.press >= CW'(ON_CYCLES - 1)
                                 |=> s_r.st == ST_RAIL_UP ##1 io_rail_out_o && !internal_reset_n_o)
      else $error("long press did not start switch-on");
   a_wake_press: assert property (s_r.st == ST_SLEEP && quiet && !switch_request_n_i
                                  && s_r.press >= CW'(WAKE_CYCLES - 1) |=> s_r.st == ST_WAKE)
      else $error("long press did not wake");
   a_wake_pin: assert property (s_r.st == ST_SLEEP && quiet && wake_trig |=> s_r.st == ST_WAKE)
      else $error("wake pin edge ignored");
   a_tri_no_rail: assert property (!io_rail_out_o |-> pin_tristate_o)
      else $error("pins driven without io rail");
   a_reset_pins: assert property ($rose(internal_reset_n_o) |-> pin_enable_o == '0
                                  ##[1:16] pin_enable_o[0])
      else $error("pin release sequence broken");
   a_ready_pins: assert property (ready_o |-> &pin_enable_o && internal_reset_n_o)
      else $error("ready before all pins configured");
   a_off_end: assert property ($fell(io_rail_out_o) && supply_valid_i
                               && s_r.st != ST_SLEEP
                               |-> pin_tristate_o && pin_enable_o == '0)
      else $error("rail off with pins live");
   a_stay_off: assert property (s_r.st == ST_OFF && switch_request_n_i |=> s_r.st == ST_OFF)
      else $error("left off state without request");
   a_erst_cut: assert property (supply_valid_i && erst_trig |=> !io_rail_out_o ##1 !io_rail_out_o)
      else $error("emergency reset did not cut rail");
   a_sleep_rail: assert property (s_r.st == ST_SLEEP |-> !io_rail_out_o && !ready_o)
      else $error("rail on in deep sleep");
   a_safe_off: assert property ($rose(flash_inhibit_o) |-> s_r.st == ST_SHUTDOWN && !nvm_store_o)
      else $error("safe off stored settings");
   a_off_ok: assert property ($rose(s_r.off_ok) |-> s_r.st == ST_STORE)
      else $error("off answer without switch-off");

   c_reach_active: cover property (s_r.st == ST_PIN_SEQ ##1 s_r.st == ST_ACTIVE);
   c_sleep_wake:   cover property (s_r.st == ST_SLEEP ##1 s_r.st == ST_WAKE);
   c_reboot:       cover property (s_r.st == ST_SHUTDOWN ##1 s_r.st == ST_RAIL_UP);
   c_abrupt:       cover property (s_r.st == ST_ABRUPT ##1 s_r.st == ST_RAIL_UP);
   c_safe_off:     cover property ($rose(flash_inhibit_o));

endmodule : module_power_state_control

`default_nettype wire

// ### power_seq_pkg.sv
/*
 * constants, types and register map of the module power-state sequencer.
 * assumes a 250 MHz system clock and a classic wishbone register bus.
 */
`default_nettype none

package power_seq_pkg;

   // ------------------------------------------------------------
   // clock and pin timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 4;
   localparam int T_ON_NS         = 1000;  // switch-on hold, least
   localparam int T_WAKE_NS       = 400;   // wake-up hold, least
   localparam int T_OFF_NS        = 2000;  // graceful off pulse, least
   localparam int T_ERST_NS       = 400;   // emergency reset hold, least
   localparam int T_RST_NS        = 800;   // internal reset held low
   localparam int T_STEP_NS       = 40;    // per-pin release step
   localparam int T_RAIL_NS       = 200;   // rail settle on wake
   localparam int T_STORE_NS      = 2000;  // settings store phase
   localparam int T_DETACH_NS     = 4000;  // network detach phase
   localparam int T_SHUT_NS       = 400;   // regulator shut-down phase

   localparam int ON_CYC     = (T_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC   = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_CYC    = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERST_CYC   = (T_ERST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CYC    = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_CYC   = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAIL_CYC   = (T_RAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STORE_CYC  = (T_STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DETACH_CYC = (T_DETACH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHUT_CYC   = (T_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FUNC_OFS = 8'h04;
   localparam logic [7:0] CFG_OFS  = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;

   localparam int CTRL_OFF_BIT   = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int STAT_READY_BIT = 4;
   localparam int STAT_RAIL_BIT  = 5;
   localparam int STAT_OK_BIT    = 6;
   localparam int STAT_SAFE_BIT  = 7;

   localparam logic [7:0] FUNC_FAST_OFF = 8'h0a;
   localparam logic [7:0] FUNC_SAFE_OFF = 8'h0b;
   localparam logic [7:0] FUNC_REBOOT   = 8'h10;
   localparam logic [2:0] LPC_WAKE_PINS = 3'h5;
   localparam logic       USB_SLP_RESUME = 1'b0;

   typedef enum logic [1:0] {PF_NONE, PF_WAKE, PF_FAST_OFF, PF_SAFE_OFF} pin_func_type;

   // cfg register, bit 0 upward: low_power[2:0], -, usb_sleep, usb_host,
   // -, -, func_a[9:8], func_b[11:10], greet[12]
   typedef struct packed {
      logic         greet;
      pin_func_type func_b;
      pin_func_type func_a;
      logic [1:0]   spare_hi;
      logic         usb_host;
      logic         usb_sleep;
      logic         spare_lo;
      logic [2:0]   low_power;
   } cfg_type;

   localparam cfg_type CFG_RESET = 13'h0010;

   typedef enum logic [3:0] {
      ST_OFF, ST_RAIL_UP, ST_PIN_SEQ, ST_ACTIVE, ST_SLEEP,
      ST_WAKE, ST_STORE, ST_DETACH, ST_SHUTDOWN, ST_ABRUPT
   } pwr_st_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_type;

endpackage : power_seq_pkg

`default_nettype wire

// ### testbench.sv
/* self-checking bench of the power sequencer with shortened timing.
   assumes host_model drives the control pins. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import power_seq_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   wb_req_type  req   = '0;
   wb_rsp_type  rsp;
   logic        sv, srn, ern, wa, wbp, usb, pu_s, pu_e, rail, rstn, tri_s, st, det, inh, rdy, gr;
   logic [7:0]  pins;
   logic [3:0]  seen  = '0;
   logic [31:0] q;
   int          mismatches = 0;
   int          checked = 0;
   int          cycles = 0;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      seen <= seen | {gr, inh, det, st};
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   host_model host_model_i (.clk_i(clk_i), .supply_valid_o(sv), .switch_request_n_o(srn),
      .emergency_reset_n_o(ern), .wake_pin_a_o(wa), .wake_pin_b_o(wbp), .usb_resume_o(usb));
   module_power_state_control #(.ON_CYCLES(4), .OFF_CYCLES(4), .RST_CYCLES(4), .STORE_CYCLES(4),
      .DETACH_CYCLES(4)) module_power_state_control_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .supply_valid_i(sv), .switch_request_n_i(srn), .emergency_reset_n_i(ern),
      .wake_pin_a_i(wa), .wake_pin_b_i(wbp), .usb_resume_i(usb), .switch_request_pullup_o(pu_s),
      .emergency_reset_pullup_o(pu_e), .io_rail_out_o(rail), .internal_reset_n_o(rstn),
      .pin_tristate_o(tri_s), .pin_enable_o(pins), .nvm_store_o(st), .net_detach_o(det),
      .flash_inhibit_o(inh), .ready_o(rdy), .greeting_o(gr));
   // ------------------------------------------
   // bus cycles, waits and compares
   // ------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i) req <= '{1'b1, 1'b1, w, 4'hf, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      r = rsp.dat;
      req <= '0;
      if (n >= 50) chk("bus ack", 32'h1, 32'h0);
   endtask : wb
   task automatic await(input logic s, input logic v);
      @(negedge clk_i);
      for (int n = 0; n < 300 && (s ? rdy : rail) !== v; n++) @(negedge clk_i);
      chk(s ? "ready" : "io rail", {31'h0, v}, {31'h0, s ? rdy : rail});
   endtask : await
   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_bus;
      wb(1'b1, CFG_OFS, 32'h0000_1fff, q);
      wb(1'b0, CFG_OFS, 32'h0, q);
      chk("cfg write while off", 32'h0000_0010, q);
      wb(1'b0, 8'h10, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      $display("bus test done");
   endtask : t_bus
   task automatic t_on;
      chk("pull-ups", 32'h3, {30'h0, pu_e, pu_s});
      chk("rail before press", 32'h0, {31'h0, rail});
      host_model_i.press(6);
      await(1'b0, 1'b1);
      chk("reset with rail up", 32'h2, {30'h0, tri_s, rstn});
      await(1'b1, 1'b1);
      chk("pins at ready", 32'h0ff, {23'h0, tri_s, pins});
      $display("switch-on test done");
   endtask : t_on
   task automatic t_off(input logic by_pin);
      seen = '0;
      if (by_pin) host_model_i.press(6);
      else begin
         wb(1'b1, CTRL_OFS, 32'h1, q);
         wb(1'b0, STAT_OFS, 32'h0, q);
         chk("off accepted", 32'h1, {31'h0, q[STAT_OK_BIT]});
      end
      await(1'b0, 1'b0);
      chk("graceful phases", 32'h3, {28'h0, seen});
      chk("pins after off", 32'h100, {23'h0, tri_s, pins});
      repeat (20) @(negedge clk_i);
      chk("stays off", 32'h0, {31'h0, rail});
      $display("graceful off test done");
      t_on();
   endtask : t_off
   task automatic t_func;
      logic [7:0] code [3] = '{FUNC_FAST_OFF, FUNC_SAFE_OFF, FUNC_REBOOT};
      logic [3:0] expv [3] = '{4'h1, 4'h4, 4'hb};
      wb(1'b1, CFG_OFS, 32'h0000_1010, q);
      foreach (code[i]) begin
         @(negedge clk_i) seen = '0;
         wb(1'b1, FUNC_OFS, {24'h0, code[i]}, q);
         if (i == 2) await(1'b1, 1'b0);
         await(i == 2, i == 2);
         repeat (2) @(negedge clk_i);
         chk("function phases", {28'h0, expv[i]}, {28'h0, seen});
         if (i != 2) t_on();
      end
      $display("function level test done");
   endtask : t_func
   task automatic t_sleep;
      wb(1'b1, CFG_OFS, 32'h0000_0125, q);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, CTRL_OFS, 32'h2, q);
         await(1'b0, 1'b0);
         wb(1'b1, FUNC_OFS, {24'h0, FUNC_SAFE_OFF}, q);
         if (i == 0) host_model_i.press(110);
         else if (i == 1) host_model_i.rise(1'b0);
         else host_model_i.resume();
         await(1'b1, 1'b1);
         chk("awake rail, no fault", 32'h1, {30'h0, inh, rail});
      end
      $display("sleep and wake test done");
   endtask : t_sleep
   task automatic t_pin_erst;
      wb(1'b1, CFG_OFS, 32'h0000_0c10, q);
      host_model_i.rise(1'b1);
      await(1'b0, 1'b0);
      chk("memory-safe by pin", 32'h1, {31'h0, inh});
      t_on();
      seen = '0;
      host_model_i.erst(1'b0);
      repeat (110) @(negedge clk_i);
      chk("abrupt reset", 32'h0, {28'h0, seen[1:0], rail, rdy});
      host_model_i.erst(1'b1);
      await(1'b1, 1'b1);
      host_model_i.supply(1'b0);
      host_model_i.press(6);
      repeat (2) @(negedge clk_i);
      chk("no switch-on without supply", 32'h0, {30'h0, rdy, rail});
      host_model_i.supply(1'b1);
      t_on();
      $display("pin off and emergency reset test done");
   endtask : t_pin_erst
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_bus();
      t_on();
      t_off(1'b0);
      t_off(1'b1);
      t_func();
      t_sleep();
      t_pin_erst();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
